// >>> four_bit_port_b_gpio_bench.sv
`timescale 1ns/1ps
module four_bit_port_b_gpio_bench;
  logic clk_i = 0;
  logic reset_i = 1;
  logic [7:0] addr_i = 0;
  logic [3:0] wdata_i = 0;
  logic wr_i = 0;
  logic rd_i = 0;
  logic t128 = 0;
  logic t4k = 0;
  logic tov_a = 0;
  logic tov_b = 0;
  logic clr = 0;
  logic [3:0] ext_v = 0;
  logic [3:0] ext_en = 0;
  wire [3:0] rdata_o, pin, pout, poe, pup, pdn;
  wire cap_a, cap_b, clk_ac, clk_bd, req, flag;
  int n_errors = 0;
  int cmp_count = 0;
  initial forever #5 clk_i = ~clk_i;
  gpb_port dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pin_in_i(pin), .pin_out_o(pout), .pin_oe_o(poe), .pin_pull_up_o(pup),
    .pin_pull_down_o(pdn), .tb_128hz_i(t128), .tb_4khz_i(t4k), .timer_a_overflow_i(tov_a),
    .timer_b_overflow_i(tov_b), .timer_a_capture_in_o(cap_a), .timer_b_capture_in_o(cap_b),
    .timer_ac_ext_clock_o(clk_ac), .timer_bd_ext_clock_o(clk_bd), .irq_flag_clear_i(clr),
    .pin_change_irq_request_o(req), .pin_change_irq_flag_o(flag));
  gpb_pins u_pins (.clk_i(clk_i), .out_i(pout), .oe_i(poe), .up_i(pup), .dn_i(pdn), .ext_v_i(ext_v),
    .ext_en_i(ext_en), .pin_o(pin));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [3:0] s, input logic [3:0] e, input string n);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e, "rdata");
  endtask
  // pulse a time base, watch a few cycles for the request
  task automatic fall(input logic fast, input logic ex);
    logic hit;
    hit = 0;
    @(posedge clk_i);
    if (fast) t4k <= 1'b1; else t128 <= 1'b1;
    @(posedge clk_i);
    t4k <= 1'b0;
    t128 <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wt(1);
      hit = hit | req;
    end
    chk({3'h0, hit}, {3'h0, ex}, "irq req");
    if (ex && !hit) end_sim();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(pdn, 4'hf, "pull down");
    chk(poe, 4'h0, "oe");
    rd(8'h2a, 4'h0);
    rd(8'h2b, 4'h0);
    rd(8'h2e, 4'h0);
    rd(8'h2f, 4'h0);
    rd(8'h30, 4'h0);
    rd(8'h31, 4'h0);
  endtask
  task automatic t_port();
    ext_v <= 4'hc;
    ext_en <= 4'hc;
    wr(8'h2b, 4'h5);
    wr(8'h2a, 4'h3);
    chk(poe, 4'h3, "oe");
    chk(pout & 4'h3, 4'h1, "out");
    wr(8'h2b, 4'h6);
    chk(pout & 4'h3, 4'h2, "out now");
    wt(3);
    rd(8'h2b, 4'he);
  endtask
  task automatic t_modes();
    wr(8'h2a, 4'hf);
    wr(8'h2b, 4'h1);
    for (int m = 0; m < 4; m++) begin
      wr(8'h2e, 4'(m));
      chk({3'h0, poe[0]}, {3'h0, ~m[0]}, "oe0");
      chk({3'h0, pout[0] | m[0]}, 4'h1, "out0");
    end
    wr(8'h2b, 4'h0);
    wr(8'h2e, 4'h1);
    chk({3'h0, poe[0]}, 4'h1, "ndrain oe");
    wr(8'h2e, 4'h0);
    wr(8'h2a, 4'h0);
    ext_en <= 4'h0;
    for (int m = 0; m < 4; m++) begin
      wr(8'h2f, 4'(m << 2));
      chk({2'h0, pup[3], pdn[3]}, {2'h0, m == 2, m == 0}, "pulls3");
      rd(8'h2f, 4'(m << 2));
    end
    wr(8'h2f, 4'h0);
  endtask
  task automatic t_irq();
    wr(8'h31, 4'h1);
    ext_en <= 4'h3;
    ext_v <= 4'h1;
    wt(4);
    fall(1'b0, 1'b1);
    chk({3'h0, flag}, 4'h1, "flag");
    ext_v <= 4'h3;
    wt(4);
    fall(1'b0, 1'b0);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    wt(1);
    chk({3'h0, flag}, 4'h0, "flag clr");
    wr(8'h30, 4'h8);
    ext_v <= 4'h2;
    wt(4);
    fall(1'b1, 1'b1);
  endtask
  task automatic t_alt();
    wr(8'h31, 4'h0);
    wr(8'h30, 4'h3);
    ext_en <= 4'hf;
    ext_v <= 4'h9;
    wt(4);
    chk({2'h0, cap_a, clk_bd}, 4'h3, "alt in");
    ext_v <= 4'h6;
    wt(4);
    chk({cap_a, cap_b, clk_ac, clk_bd}, 4'h6, "alt in2");
    ext_en <= 4'h0;
    wr(8'h2a, 4'h3);
    wr(8'h2b, 4'h0);
    wr(8'h30, 4'h4);
    @(posedge clk_i);
    tov_a <= 1'b1;
    tov_b <= 1'b1;
    wt(3);
    chk({3'h0, pout[0]}, 4'h1, "ovf out");
    chk({3'h0, pout[1]}, 4'h1, "ovf out b");
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    wt(1);
    t_reset();
    t_port();
    t_modes();
    t_irq();
    t_alt();
    end_sim();
  end
endmodule

// >>> gpb_assertions.sv
`timescale 1ns/1ps
`include "gpb_regs.svh"
module gpb_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic rd_i,
  input wire logic [3:0] rdata_o,
  input wire logic [3:0] pin_in_i,
  input wire logic [3:0] pin_oe_o,
  input wire logic [3:0] pin_pull_up_o,
  input wire logic [3:0] pin_pull_down_o,
  input wire logic wr_i,
  input wire logic tb_128hz_i,
  input wire logic tb_4khz_i,
  input wire logic timer_a_capture_in_o,
  input wire logic timer_bd_ext_clock_o,
  input wire logic irq_flag_clear_i,
  input wire logic pin_change_irq_request_o,
  input wire logic pin_change_irq_flag_o
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // clear seen while no new request lands
  sequence s_clr;
    irq_flag_clear_i ##1 !pin_change_irq_request_o;
  endsequence
  AST_RD_ONE: assert property (!$past(rd_i) |-> rdata_o == 4'h0) else $error("read data off slot");
  AST_REQ_PULSE: assert property (pin_change_irq_request_o |=> !pin_change_irq_request_o) else $error("long req");
  AST_REQ_FLAG: assert property (pin_change_irq_request_o |-> pin_change_irq_flag_o) else $error("flag not set");
  AST_FLAG_CLR: assert property (s_clr |-> !pin_change_irq_flag_o) else $error("flag not cleared");
  AST_FLAG_HOLD: assert property (pin_change_irq_flag_o && !irq_flag_clear_i |=> pin_change_irq_flag_o)
    else $error("flag lost");
  AST_REQ_FALL: assert property (pin_change_irq_request_o |-> ($past(tb_128hz_i, 2) && !$past(tb_128hz_i))
    || ($past(tb_4khz_i, 2) && !$past(tb_4khz_i))) else $error("req without fall");
  AST_PULL_OUT: assert property ((pin_oe_o & (pin_pull_up_o | pin_pull_down_o)) == 4'h0)
    else $error("pull while driving");
  AST_PULL_ONE: assert property ((pin_pull_up_o & pin_pull_down_o) == 4'h0) else $error("both pulls");
  AST_PULL_WR: assert property ($changed(pin_pull_up_o) |-> $past(wr_i)) else $error("pull change w/o write");
  AST_CAP_A: assert property (timer_a_capture_in_o |-> $past(pin_in_i[0], 3)) else $error("capture w/o pin");
  AST_CLK_BD: assert property (timer_bd_ext_clock_o |-> $past(pin_in_i[3], 3)) else $error("clock w/o pin");
endmodule
bind gpb_port gpb_chk u_chk (.clk_i(clk_i), .reset_i(reset_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pin_in_i(pin_in_i), .pin_oe_o(pin_oe_o), .pin_pull_up_o(pin_pull_up_o), .pin_pull_down_o(pin_pull_down_o),
  .wr_i(wr_i), .tb_128hz_i(tb_128hz_i), .tb_4khz_i(tb_4khz_i), .timer_a_capture_in_o(timer_a_capture_in_o),
  .timer_bd_ext_clock_o(timer_bd_ext_clock_o), .irq_flag_clear_i(irq_flag_clear_i),
  .pin_change_irq_request_o(pin_change_irq_request_o), .pin_change_irq_flag_o(pin_change_irq_flag_o));

// >>> gpb_pins.sv
`timescale 1ns/1ps
module gpb_pins (
  input wire logic clk_i,
  input wire logic [3:0] out_i,
  input wire logic [3:0] oe_i,
  input wire logic [3:0] up_i,
  input wire logic [3:0] dn_i,
  input wire logic [3:0] ext_v_i,
  input wire logic [3:0] ext_en_i,
  output logic [3:0] pin_o
);
  logic [3:0] last_q = 4'h0;
  // ----------------------------------------
  // wire level
  // ----------------------------------------
  // resolve drivers and pulls
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (oe_i[i])
        pin_o[i] = out_i[i];
      else if (ext_en_i[i])
        pin_o[i] = ext_v_i[i];
      else if (up_i[i])
        pin_o[i] = 1'b1;
      else if (dn_i[i])
        pin_o[i] = 1'b0;
      else
        pin_o[i] = ~last_q[i]; // floating wire never holds
    end
  end
  always @(posedge clk_i) last_q <= pin_o;
endmodule

// >>> gpb_pkg.sv
package gpb_pkg;
`include "gpb_regs.svh"

  typedef logic [`GPB_PIN_W-1:0] gpb_nib_type;
  typedef logic [`GPB_MODE_W-1:0] gpb_mode_type;

  // ----------------------------------------
  // synchroniser state
  // ----------------------------------------
  typedef struct packed {
    gpb_nib_type stage1;
    gpb_nib_type stage2;
  } gpb_sync_type;

  // ----------------------------------------
  // port state
  // ----------------------------------------
  typedef struct packed {
    gpb_nib_type dir;
    gpb_nib_type data;
    gpb_nib_type con_lo;
    gpb_nib_type con_hi;
    gpb_nib_type alt;
    gpb_nib_type irq_en;
    gpb_nib_type rdata;
    gpb_nib_type pin_out;
    gpb_nib_type pin_oe;
    gpb_nib_type pull_up;
    gpb_nib_type pull_down;
    logic cap_a;
    logic cap_b;
    logic clk_ac;
    logic clk_bd;
    logic tb_prev;
    gpb_nib_type sample;
    logic irq_req;
    logic irq_flag;
  } gpb_state_type;

endpackage

// >>> gpb_port.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "gpb_regs.svh"

// Notes on behaviour
// - direction bit 0 input, 1 output
// - reset clears direction: all inputs
// - data register drives output pins
// - output pin reads stored data bit
// - input pin reads live pin level
// - reset clears data register
// - pins change at the write edge
// - reset clears both mode registers
// - input: 00 pull-down, 10 pull-up, x1 hi-z
// - output: cmos, n-drain, p-drain, hi-z
// - high mode register holds pins 3,2
// - alternate register bit 3 picks 128 Hz or 4 kHz
// - alternate capture and clock inputs
// - pins 0,1 may drive overflow flags
// - all pins feed pin-change interrupt
// - per-pin interrupt enable, reset disabled
// - sample on sampling clock falling edge
// - request and flag within one sample
// - no record of which pin changed
module gpb_port (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [`GPB_ADDR_W-1:0] addr_i,
  input wire gpb_pkg::gpb_nib_type wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output gpb_pkg::gpb_nib_type rdata_o,
  input wire gpb_pkg::gpb_nib_type pin_in_i,
  output gpb_pkg::gpb_nib_type pin_out_o,
  output gpb_pkg::gpb_nib_type pin_oe_o,
  output gpb_pkg::gpb_nib_type pin_pull_up_o,
  output gpb_pkg::gpb_nib_type pin_pull_down_o,
  input wire logic tb_128hz_i,
  input wire logic tb_4khz_i,
  input wire logic timer_a_overflow_i,
  input wire logic timer_b_overflow_i,
  output logic timer_a_capture_in_o,
  output logic timer_b_capture_in_o,
  output logic timer_ac_ext_clock_o,
  output logic timer_bd_ext_clock_o,
  input wire logic irq_flag_clear_i,
  output logic pin_change_irq_request_o,
  output logic pin_change_irq_flag_o
);

  // ----------------------------------------
  // state and synchronised pins
  // ----------------------------------------
  gpb_pkg::gpb_state_type state_q;
  gpb_pkg::gpb_state_type state_d;
  gpb_pkg::gpb_nib_type pin_sync;

  // pins come from outside the clock domain
  // only the second stage is read past here
  gpb_sync u_pin_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(pin_in_i),
    .sync_o(pin_sync)
  );

  // ----------------------------------------
  // per-pin decode of registered state
  // ----------------------------------------
  // reads only flops and synced pins, so it
  // closes no loop through the next-state copy
  wire gpb_pkg::gpb_nib_type pin_read;
  wire gpb_pkg::gpb_nib_type pin_diff;
  wire gpb_pkg::gpb_nib_type alt_in;

  for (genvar g = 0; g < `GPB_PIN_W; g++) begin : g_pin
    assign pin_read[g] = state_q.dir[g] ? state_q.data[g] : pin_sync[g];
    assign pin_diff[g] = (pin_sync[g] ^ state_q.sample[g]) & state_q.irq_en[g];
    if (g < `GPB_PIN_AC_CLK) begin : g_cap
      assign alt_in[g] = state_q.alt[`GPB_ALT_CAPTURE] & pin_sync[g];
    end else begin : g_clk
      assign alt_in[g] = state_q.alt[`GPB_ALT_EXT_CLOCK] & pin_sync[g];
    end
  end

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  // locals are set at the top of the process
  always_comb begin
    logic [2*`GPB_PIN_W-1:0] modes;
    gpb_pkg::gpb_mode_type mode;
    gpb_pkg::gpb_nib_type drive;
    gpb_pkg::gpb_nib_type changed;
    logic tb_sel;
    logic tb_fall;

    state_d = state_q;
    modes = '0;
    mode = '0;
    drive = '0;
    changed = '0;
    tb_sel = 1'b0;
    tb_fall = 1'b0;

    // ----------------------------------------
    // software writes
    // ----------------------------------------
    // register writes; pins follow at this same edge
    if (wr_i) begin
      unique case (addr_i)
        `GPB_ADDR_DIR: begin
          state_d.dir = wdata_i;
        end
        `GPB_ADDR_DATA: begin
          state_d.data = wdata_i;
        end
        `GPB_ADDR_CON_LO: begin
          state_d.con_lo = wdata_i;
        end
        `GPB_ADDR_CON_HI: begin
          state_d.con_hi = wdata_i;
        end
        `GPB_ADDR_ALT: begin
          state_d.alt = wdata_i;
        end
        `GPB_ADDR_IRQ_EN: begin
          state_d.irq_en = wdata_i;
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // read data live for one cycle only
    // zero outside its slot, so idle cycles leak nothing
    state_d.rdata = `GPB_RDATA_NONE;
    if (rd_i) begin
      unique case (addr_i)
        `GPB_ADDR_DIR: begin
          state_d.rdata = state_q.dir;
        end
        `GPB_ADDR_DATA: begin
          state_d.rdata = pin_read;
        end
        `GPB_ADDR_CON_LO: begin
          state_d.rdata = state_q.con_lo;
        end
        `GPB_ADDR_CON_HI: begin
          state_d.rdata = state_q.con_hi;
        end
        `GPB_ADDR_ALT: begin
          state_d.rdata = state_q.alt;
        end
        `GPB_ADDR_IRQ_EN: begin
          state_d.rdata = state_q.irq_en;
        end
        // unmapped reads answer zero
        default: begin
          state_d.rdata = `GPB_RDATA_NONE;
        end
      endcase
    end

    // ----------------------------------------
    // pad drive
    // ----------------------------------------
    // decoded from next values so pins move at the write edge
    // value each pin drives, overflow may replace data
    drive = state_d.data;
    // overflow reaches a pin only while it is an output
    // overflow flags onto pins 0,1
    if (state_d.alt[`GPB_ALT_OVERFLOW]) begin
      drive[`GPB_PIN_A_CAP] = timer_a_overflow_i;
      drive[`GPB_PIN_B_CAP] = timer_b_overflow_i;
    end

    // pad controls from the new register values
    modes = {state_d.con_hi, state_d.con_lo};
    for (int i = 0; i < `GPB_PIN_W; i++) begin
      mode = modes[`GPB_MODE_W*i +: `GPB_MODE_W];
      state_d.pin_out[i] = 1'b0;
      state_d.pin_oe[i] = 1'b0;
      state_d.pull_up[i] = 1'b0;
      state_d.pull_down[i] = 1'b0;
      if (state_d.dir[i]) begin
        unique case (mode)
          `GPB_MODE_CMOS: begin
            state_d.pin_out[i] = drive[i];
            state_d.pin_oe[i] = 1'b1;
          end
          `GPB_MODE_N_DRAIN: begin
            state_d.pin_out[i] = 1'b0;
            state_d.pin_oe[i] = ~drive[i];
          end
          `GPB_MODE_P_DRAIN: begin
            state_d.pin_out[i] = 1'b1;
            state_d.pin_oe[i] = drive[i];
          end
          `GPB_MODE_HIZ: begin
            state_d.pin_oe[i] = 1'b0;
          end
        endcase
      end else begin
        if (mode[`GPB_MODE_HIZ_IN_BIT]) begin
          state_d.pull_up[i] = 1'b0;
        end else if (mode == `GPB_MODE_PULL_UP) begin
          state_d.pull_up[i] = 1'b1;
        end else begin
          state_d.pull_down[i] = 1'b1;
        end
      end
    end

    // ----------------------------------------
    // alternate inputs
    // ----------------------------------------
    // alternate inputs do not force input direction
    // alternate inputs to the timers
    state_d.cap_a = alt_in[`GPB_PIN_A_CAP];
    state_d.cap_b = alt_in[`GPB_PIN_B_CAP];
    state_d.clk_ac = alt_in[`GPB_PIN_AC_CLK];
    state_d.clk_bd = alt_in[`GPB_PIN_BD_CLK];

    // ----------------------------------------
    // pin-change sampling
    // ----------------------------------------
    // switching rate may look like one falling edge
    // sampling rate select
    if (state_q.alt[`GPB_ALT_RATE] == `GPB_RATE_4KHZ) begin
      tb_sel = tb_4khz_i;
    end else begin
      tb_sel = tb_128hz_i;
    end
    // history of the chosen time base
    state_d.tb_prev = tb_sel;
    // falling edge of the time base
    tb_fall = state_q.tb_prev & ~tb_sel;

    // request is a one-cycle pulse per sample that sees an enabled pin change
    state_d.irq_req = 1'b0;
    if (tb_fall) begin
      // every enabled pin is a source
      // sample kept for every pin, enabled or not
      state_d.sample = pin_sync;
      changed = pin_diff;
      if (|changed) begin
        state_d.irq_req = 1'b1;
      end
    end

    // ----------------------------------------
    // interrupt flag
    // ----------------------------------------
    // flag sticks; a set in the clear cycle wins
    if (irq_flag_clear_i) begin
      state_d.irq_flag = 1'b0;
    end
    if (state_d.irq_req) begin
      state_d.irq_flag = 1'b1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // direction cleared, pins inputs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q.dir <= `GPB_RST_DIR;
      state_q.data <= `GPB_RST_DATA;
      state_q.con_lo <= `GPB_RST_CON;
      state_q.con_hi <= `GPB_RST_CON;
      state_q.alt <= `GPB_RST_ALT;
      state_q.irq_en <= `GPB_RST_IRQ_EN;
      state_q.rdata <= `GPB_RDATA_NONE;
      // pads come up as pulled-down inputs
      state_q.pin_out <= '0;
      state_q.pin_oe <= '0;
      state_q.pull_up <= '0;
      state_q.pull_down <= '1;
      state_q.cap_a <= '0;
      state_q.cap_b <= '0;
      state_q.clk_ac <= '0;
      state_q.clk_bd <= '0;
      // edge history starts at the idle low level
      state_q.tb_prev <= '0;
      state_q.sample <= '0;
      state_q.irq_req <= '0;
      state_q.irq_flag <= '0;
    end else begin
      // pins update on the write edge
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------
  // register bus
  assign rdata_o = state_q.rdata;
  // pads
  assign pin_out_o = state_q.pin_out;
  assign pin_oe_o = state_q.pin_oe;
  assign pin_pull_up_o = state_q.pull_up;
  assign pin_pull_down_o = state_q.pull_down;
  // timers and interrupt
  assign timer_a_capture_in_o = state_q.cap_a;
  assign timer_b_capture_in_o = state_q.cap_b;
  assign timer_ac_ext_clock_o = state_q.clk_ac;
  assign timer_bd_ext_clock_o = state_q.clk_bd;
  assign pin_change_irq_request_o = state_q.irq_req;
  assign pin_change_irq_flag_o = state_q.irq_flag;

endmodule

// >>> gpb_regs.svh
`ifndef GPB_REGS_SVH
`define GPB_REGS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define GPB_PIN_W 4
`define GPB_ADDR_W 8
`define GPB_MODE_W 2

// ----------------------------------------
// register addresses
// ----------------------------------------
`define GPB_ADDR_DIR 8'h2a
`define GPB_ADDR_DATA 8'h2b
`define GPB_ADDR_CON_LO 8'h2e
`define GPB_ADDR_CON_HI 8'h2f
`define GPB_ADDR_ALT 8'h30
`define GPB_ADDR_IRQ_EN 8'h31

// ----------------------------------------
// reset values
// ----------------------------------------
`define GPB_RST_DIR 4'h0
`define GPB_RST_DATA 4'h0
`define GPB_RST_CON 4'h0
`define GPB_RST_ALT 4'h0
`define GPB_RST_IRQ_EN 4'h0
`define GPB_RDATA_NONE 4'h0

// ----------------------------------------
// pin mode field codes
// ----------------------------------------
`define GPB_MODE_PULL_DOWN 2'h0
`define GPB_MODE_PULL_UP 2'h2
`define GPB_MODE_CMOS 2'h0
`define GPB_MODE_N_DRAIN 2'h1
`define GPB_MODE_P_DRAIN 2'h2
`define GPB_MODE_HIZ 2'h3
`define GPB_MODE_HIZ_IN_BIT 0

// ----------------------------------------
// alternate function select bits
// ----------------------------------------
`define GPB_ALT_CAPTURE 0
`define GPB_ALT_EXT_CLOCK 1
`define GPB_ALT_OVERFLOW 2
`define GPB_ALT_RATE 3
`define GPB_RATE_4KHZ 1'h1

// ----------------------------------------
// pin roles of the alternate functions
// ----------------------------------------
`define GPB_PIN_A_CAP 0
`define GPB_PIN_B_CAP 1
`define GPB_PIN_AC_CLK 2
`define GPB_PIN_BD_CLK 3

`endif

// >>> gpb_sync.sv
`timescale 1ns/1ps
module gpb_sync (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire gpb_pkg::gpb_nib_type async_i,
  output gpb_pkg::gpb_nib_type sync_o
);

  gpb_pkg::gpb_sync_type state_q;
  gpb_pkg::gpb_sync_type state_d;

  // two stages; only the second stage is looked at
  always_comb begin
    state_d = state_q;
    state_d.stage1 = async_i;
    state_d.stage2 = state_q.stage1;
  end

  // constant reset only
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_o = state_q.stage2;

endmodule
